// ### design/irq_regs_pkg.sv
// register map, field layout and encodings of the posted/pending interrupt controller
package irq_regs_pkg;
  localparam int NUM_SRC = 22;
  localparam int IDX_W = 5;
  localparam int GRP_W = 8;
  localparam int UPPER_W = 6;
  localparam int LOW_LSB = 0;
  localparam int MID_LSB = 8;
  localparam int UP_LSB = 16;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CLEAR_LOW = 8'hda;
  localparam logic [7:0] IDX_CLEAR_MIDDLE = 8'hdb;
  localparam logic [7:0] IDX_CLEAR_UPPER = 8'hdc;
  localparam logic [7:0] IDX_MASK_UPPER = 8'hde;
  localparam logic [7:0] IDX_MASK_MIDDLE = 8'hdf;
  localparam logic [7:0] IDX_MASK_LOW = 8'he0;
  localparam logic [7:0] IDX_SOFT_EN = 8'he1;
  localparam logic [7:0] IDX_VECTOR = 8'he2;
  localparam logic [7:0] IDX_EVT_STATUS = 8'he4;
  localparam logic [7:0] IDX_EVT_CLEAR = 8'he5;
  localparam logic [7:0] IDX_EVT_ENABLE = 8'he6;
  localparam logic [7:0] IDX_CPU_FLAGS = 8'hf7;
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 9;
  localparam int ADDR_HI_LSB = 10;
  localparam int TRANS_ACTIVE_BIT = 1;
  // field positions
  localparam int SOFT_EN_BIT = 0;
  localparam int GATE_BIT = 0;
  localparam int EV_HW_POST = 0;
  localparam int EV_SW_POST = 1;
  localparam int EV_BULK = 2;
  localparam int EV_SERVICE = 3;
  localparam int EV_W = 4;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [NUM_SRC-1:0] RST_POSTED = 22'h00_0000;
  localparam logic [EV_W-1:0] RST_EV = 4'h0;
  // vector encoding: base plus step times source index, zero when idle
  localparam logic [7:0] VEC_NONE = 8'h00;
  localparam logic [7:0] VEC_BASE = 8'h04;
  localparam logic [7:0] VEC_STEP = 8'h04;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [23:0] RDATA_PAD = 24'h00_0000;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b10,
    BUS_READ = 2'b01,
    BUS_READY = 2'b11
  } bus_state_t;
endpackage

// ### design/posted_pending_irq_regs.sv
// interrupt controller registers: posting, masking, vectoring behind an AHB-Lite slave
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// - clear register reads return posted bits
// - write 0, soft disabled: withdraw posted
// - write 1, soft enabled: post interrupt
// - other clear writes leave posted unchanged
// - upper clear: wake bit5, endpoints 8..4
// - mask bit 0 masks, 1 unmasks
// - masked sources still post, never pend
// - upper mask: wake bit5, endpoints 8..4
// - middle mask: endpoints, frame, reset, timers
// - low mask: eight peripheral sources by bit
// - soft enable bit 0 gates software posting
// - vector read gives highest priority pending
// - vector write clears all posted state
// - global gate blocks or allows servicing
// - service entry clears the flag word
module posted_pending_irq_regs
  import irq_regs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic [NUM_SRC-1:0] src_event,
  output logic irq_req,
  output logic [7:0] irq_vector,
  input wire logic irq_ack,
  output logic irq_out
);

  bus_state_t state_q, state_d;
  logic [7:0] reg_idx_q;
  logic addr_ok_q;
  logic [7:0] rdata_q;
  logic [NUM_SRC-1:0] posted_q, posted_d;
  logic [NUM_SRC-1:0] mask_q;
  logic soft_en_q;
  logic [7:0] cpu_flags_q;
  logic [EV_W-1:0] ev_status_q, ev_enable_q;
  logic req_q;
  logic [IDX_W-1:0] idx_q;
  logic [7:0] vec_q;

  // lowest source index has the highest priority
  function automatic logic [IDX_W:0] find_top(input logic [NUM_SRC-1:0] p);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = {1'b1, IDX_W'(i)};
      end
    end
    return r;
  endfunction

  // bus address and data phase
  wire accept = hsel & hready & htrans[TRANS_ACTIVE_BIT];
  wire wr_phase = (state_q == BUS_WRITE) & addr_ok_q;
  wire rd_phase = (state_q == BUS_READ) & addr_ok_q;
  wire [7:0] wbyte = hwdata[7:0];

  wire wr_clr_low = wr_phase & (reg_idx_q == IDX_CLEAR_LOW);
  wire wr_clr_mid = wr_phase & (reg_idx_q == IDX_CLEAR_MIDDLE);
  wire wr_clr_up = wr_phase & (reg_idx_q == IDX_CLEAR_UPPER);
  wire wr_msk_up = wr_phase & (reg_idx_q == IDX_MASK_UPPER);
  wire wr_msk_mid = wr_phase & (reg_idx_q == IDX_MASK_MIDDLE);
  wire wr_msk_low = wr_phase & (reg_idx_q == IDX_MASK_LOW);
  wire wr_soft_en = wr_phase & (reg_idx_q == IDX_SOFT_EN);
  wire wr_vector = wr_phase & (reg_idx_q == IDX_VECTOR);
  wire wr_ev_clr = wr_phase & (reg_idx_q == IDX_EVT_CLEAR);
  wire wr_ev_en = wr_phase & (reg_idx_q == IDX_EVT_ENABLE);
  wire wr_flags = wr_phase & (reg_idx_q == IDX_CPU_FLAGS);
  wire rd_vector = rd_phase & (reg_idx_q == IDX_VECTOR);

  // clear-register writes, spread over all sources; reserved upper bits dropped
  wire [NUM_SRC-1:0] grp_sel = {{UPPER_W{wr_clr_up}}, {GRP_W{wr_clr_mid}},
                                {GRP_W{wr_clr_low}}};
  wire [NUM_SRC-1:0] wbits = {wbyte[UPPER_W-1:0], wbyte, wbyte};
  wire [NUM_SRC-1:0] soft_clear = grp_sel & ~wbits & {NUM_SRC{~soft_en_q}};
  wire [NUM_SRC-1:0] soft_post = grp_sel & wbits & {NUM_SRC{soft_en_q}};

  // pending is posted and unmasked; the gate only stops presentation
  wire [NUM_SRC-1:0] pending = posted_q & mask_q;
  wire [IDX_W:0] top = find_top(pending);
  wire top_found = top[IDX_W];
  wire [IDX_W-1:0] top_idx = top[IDX_W-1:0];
  wire [7:0] vec_w = top_found ? 8'(VEC_BASE + VEC_STEP * 8'(top_idx)) : VEC_NONE;
  wire gate = cpu_flags_q[GATE_BIT];
  wire service = irq_ack & req_q;

  // serviced source loses its posted state, from the core or a vector read
  wire [NUM_SRC-1:0] svc_core = service ? (NUM_SRC'(1) << idx_q) : '0;
  wire [NUM_SRC-1:0] svc_read = (rd_vector & top_found) ? (NUM_SRC'(1) << top_idx) : '0;
  wire [NUM_SRC-1:0] bulk = {NUM_SRC{wr_vector}};

  // hardware and software posts win over any clear in the same cycle
  assign posted_d = (posted_q & ~soft_clear & ~svc_core & ~svc_read & ~bulk)
                    | soft_post | src_event;

  wire [EV_W-1:0] ev_now = {service, wr_vector, |soft_post, |src_event};
  wire [EV_W-1:0] ev_clr = wr_ev_clr ? wbyte[EV_W-1:0] : '0;

  // read mux for the data phase
  wire [7:0] rd_mux =
    (reg_idx_q == IDX_CLEAR_LOW) ? posted_q[MID_LSB-1:LOW_LSB] :
    (reg_idx_q == IDX_CLEAR_MIDDLE) ? posted_q[UP_LSB-1:MID_LSB] :
    (reg_idx_q == IDX_CLEAR_UPPER) ? 8'(posted_q[NUM_SRC-1:UP_LSB]) :
    (reg_idx_q == IDX_MASK_UPPER) ? 8'(mask_q[NUM_SRC-1:UP_LSB]) :
    (reg_idx_q == IDX_MASK_MIDDLE) ? mask_q[UP_LSB-1:MID_LSB] :
    (reg_idx_q == IDX_MASK_LOW) ? mask_q[MID_LSB-1:LOW_LSB] :
    (reg_idx_q == IDX_SOFT_EN) ? 8'(soft_en_q) :
    (reg_idx_q == IDX_VECTOR) ? vec_w :
    (reg_idx_q == IDX_EVT_STATUS) ? 8'(ev_status_q) :
    (reg_idx_q == IDX_EVT_ENABLE) ? 8'(ev_enable_q) :
    (reg_idx_q == IDX_CPU_FLAGS) ? cpu_flags_q : RST_BYTE;

  always_comb begin
    case (state_q)
      BUS_READ: state_d = BUS_READY;
      default: begin
        if (accept) begin
          state_d = hwrite ? BUS_WRITE : BUS_READ;
        end else begin
          state_d = BUS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= BUS_IDLE;
      reg_idx_q <= RST_BYTE;
      addr_ok_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (accept) begin
        reg_idx_q <= haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
        addr_ok_q <= (haddr[31:ADDR_HI_LSB] == '0);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_q <= RST_BYTE;
    end else if (state_q == BUS_READ) begin
      rdata_q <= addr_ok_q ? rd_mux : RST_BYTE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      posted_q <= RST_POSTED;
    end else begin
      posted_q <= posted_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mask_q <= RST_POSTED;
    end else begin
      if (wr_msk_low) mask_q[MID_LSB-1:LOW_LSB] <= wbyte;
      if (wr_msk_mid) mask_q[UP_LSB-1:MID_LSB] <= wbyte;
      if (wr_msk_up) mask_q[NUM_SRC-1:UP_LSB] <= wbyte[UPPER_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      soft_en_q <= 1'b0;
    end else if (wr_soft_en) begin
      soft_en_q <= wbyte[SOFT_EN_BIT];
    end
  end

  // service entry wins over a flag write in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cpu_flags_q <= RST_BYTE;
    end else if (service) begin
      cpu_flags_q <= RST_BYTE;
    end else if (wr_flags) begin
      cpu_flags_q <= wbyte;
    end
  end

  // request and vector toward the core; only the request is gated by the flag word
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      req_q <= 1'b0;
      idx_q <= '0;
      vec_q <= VEC_NONE;
    end else begin
      req_q <= gate & top_found & ~service;
      idx_q <= top_idx;
      vec_q <= vec_w;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ev_status_q <= RST_EV;
      ev_enable_q <= RST_EV;
    end else begin
      ev_status_q <= (ev_status_q & ~ev_clr) | ev_now;
      if (wr_ev_en) ev_enable_q <= wbyte[EV_W-1:0];
    end
  end

  assign hrdata = {RDATA_PAD, rdata_q};
  assign hreadyout = (state_q != BUS_READ);
  assign hresp = HRESP_OKAY;
  assign irq_req = req_q;
  assign irq_vector = vec_q;
  assign irq_out = |(ev_status_q & ev_enable_q);

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_clear_read_posted: assert property (
    rd_phase && reg_idx_q == IDX_CLEAR_LOW |=> hrdata[7:0] == $past(posted_q[7:0]))
    else $error("clear register read does not show posted state");

  a_soft_clear_drop: assert property (
    wr_clr_low && !soft_en_q && !wbyte[0] && !src_event[0] |=> !posted_q[0])
    else $error("write of zero did not withdraw posted source");

  a_soft_post_set: assert property (
    wr_clr_up && soft_en_q && wbyte[5] |=> posted_q[21])
    else $error("software post did not reach posted state");

  a_no_effect_write: assert property (
    wr_clr_mid && (soft_en_q != wbyte[2]) && !src_event[10] && !svc_core[10]
    |=> posted_q[10] == $past(posted_q[10]))
    else $error("no-effect clear write changed posted state");

  a_masked_still_posts: assert property (
    src_event[3] && !mask_q[3] && !wr_msk_low
    |=> posted_q[3] && !pending[3] ##0 !(irq_req && idx_q == 5'd3))
    else $error("masked source did not post or became pending");

  a_vector_read_top: assert property (
    rd_vector |=> hrdata[7:0] == $past(vec_w))
    else $error("vector read returned wrong value");

  a_vector_idle_zero: assert property (
    rd_vector && pending == '0 |=> hrdata[7:0] == VEC_NONE)
    else $error("idle vector read not zero");

  a_bulk_clear: assert property (
    wr_vector && src_event == '0 |=> posted_q == '0 ##1 !irq_req)
    else $error("vector write did not clear everything");

  a_gate_blocks: assert property (
    irq_req |-> $past(gate) && $past(pending) != '0)
    else $error("request presented while gate closed or nothing pending");

  a_service_flags: assert property (
    service |=> cpu_flags_q == RST_BYTE ##1 !irq_req)
    else $error("service entry did not clear flag word");

  a_service_withdraw: assert property (
    service && !src_event[idx_q] && !soft_post[idx_q] |=> !posted_q[$past(idx_q)])
    else $error("serviced source still posted");

  a_read_wait: assert property (
    state_q == BUS_READ |-> !hreadyout ##1 hreadyout)
    else $error("read data phase wait state wrong");

  a_write_no_wait: assert property (
    state_q == BUS_WRITE |-> hreadyout)
    else $error("write data phase inserted a wait state");

  a_clear_upper_read: assert property (
    rd_phase && reg_idx_q == IDX_CLEAR_UPPER |=> hrdata[7:0] == 8'($past(posted_q[NUM_SRC-1:UP_LSB])))
    else $error("upper clear register read wrong or reserved bits set");

  a_clear_middle_read: assert property (
    rd_phase && reg_idx_q == IDX_CLEAR_MIDDLE |=> hrdata[7:0] == $past(posted_q[UP_LSB-1:MID_LSB]))
    else $error("middle clear register read does not show posted state");

  a_mask_upper_map: assert property (
    wr_msk_up |=> mask_q[NUM_SRC-1:UP_LSB] == $past(wbyte[UPPER_W-1:0]))
    else $error("upper mask write landed on wrong sources");

  a_mask_middle_map: assert property (
    wr_msk_mid |=> mask_q[UP_LSB-1:MID_LSB] == $past(wbyte))
    else $error("middle mask write landed on wrong sources");

  a_mask_low_map: assert property (
    wr_msk_low |=> mask_q[MID_LSB-1:LOW_LSB] == $past(wbyte))
    else $error("low mask write landed on wrong sources");

  a_soft_enable_bit: assert property (
    wr_soft_en |=> soft_en_q == $past(wbyte[SOFT_EN_BIT]))
    else $error("soft post enable not taken from its bit");

  a_req_source_pending: assert property (
    irq_req |-> $past(pending[top_idx]))
    else $error("request names a source that was not pending");

  a_req_top_priority: assert property (
    irq_req |-> ($past(pending) & ((NUM_SRC'(1) << idx_q) - NUM_SRC'(1))) == '0)
    else $error("request skipped a higher priority pending source");

  a_gate_closed_idle: assert property (
    !gate |=> !irq_req)
    else $error("request raised while the gate was closed");

  a_idle_vector_out: assert property (
    pending == '0 |=> irq_vector == VEC_NONE)
    else $error("vector toward the core not zero while idle");

  a_service_event: assert property (
    service |=> ev_status_q[EV_SERVICE])
    else $error("service entry did not set its status bit");

  a_bulk_event: assert property (
    wr_vector |=> ev_status_q[EV_BULK])
    else $error("vector write did not set its status bit");

  a_event_clear: assert property (
    wr_ev_clr && ev_now == '0 |=> (ev_status_q & $past(ev_clr)) == '0)
    else $error("status clear left written bits set");

  c_soft_post: cover property (wr_clr_low && soft_en_q && wbyte != '0);
  c_bulk_clear: cover property (wr_vector && posted_q != '0);
  c_service: cover property (irq_req ##1 service);
  c_irq_out: cover property (irq_out);
  c_masked_post: cover property (src_event[3] && !mask_q[3]);

endmodule

// ### testbench/core_model.sv
// processor core and peripheral source model: posts source events, acknowledges requests
`timescale 1ns/1ps
module core_model
  import irq_regs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic post_go,
  input wire logic [NUM_SRC-1:0] post_bits,
  input wire logic ack_en,
  input wire logic [3:0] ack_delay,
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  output logic [NUM_SRC-1:0] src_event,
  output logic irq_ack,
  output logic [7:0] taken_vec_q
);
  logic [3:0] wait_q;

  // ack is a one-cycle pulse; a request still seen after it restarts the wait and is acked again
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      src_event <= '0;
      irq_ack <= 1'b0;
      wait_q <= 4'h0;
      taken_vec_q <= 8'h00;
    end else begin
      src_event <= post_go ? post_bits : '0;
      irq_ack <= 1'b0;
      if (irq_ack || !irq_req) begin
        wait_q <= 4'h0;
      end else if (ack_en && wait_q >= ack_delay) begin
        irq_ack <= 1'b1;
        taken_vec_q <= irq_vector;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule

// ### testbench/posted_pending_irq_regs_tb.sv
// self-checking bench: register access, posting, masking, vectoring, service, event output
`timescale 1ns/1ps
module posted_pending_irq_regs_tb;
  import irq_regs_pkg::*;
  logic clock, rst_n, hsel, hwrite, post_go, ack_en, hreadyout, irq_req, irq_ack, irq_out;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [NUM_SRC-1:0] post_bits, src_event;
  logic [7:0] irq_vector, taken_vec;
  logic [3:0] ack_delay;
  logic [7:0] reset_list [9] = '{IDX_CLEAR_LOW, IDX_CLEAR_MIDDLE, IDX_CLEAR_UPPER,
    IDX_MASK_UPPER, IDX_MASK_MIDDLE, IDX_MASK_LOW, IDX_SOFT_EN, IDX_VECTOR, 8'hf0};
  int err_count, check_count, cycles;

  posted_pending_irq_regs DUT (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_event(src_event),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_out(irq_out));

  core_model core (.clock(clock), .rst_n(rst_n), .post_go(post_go), .post_bits(post_bits),
    .ack_en(ack_en), .ack_delay(ack_delay), .irq_req(irq_req), .irq_vector(irq_vector),
    .src_event(src_event), .irq_ack(irq_ack), .taken_vec_q(taken_vec));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_ready();
    do @(posedge clock); while (hreadyout !== 1'b1);
  endtask

  // one single word transfer; read data taken at the edge ending the data phase
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {22'h00_0000, idx, 2'b00};
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    wait_ready();
    rdata = hrdata;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rdata, {24'h00_0000, exp});
    chk(32'(hresp), 32'(HRESP_OKAY));
  endtask

  task automatic post(input logic [NUM_SRC-1:0] bits);
    post_bits <= bits;
    post_go <= 1'b1;
    @(posedge clock);
    post_go <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = '0;
    hwdata = '0;
    post_go = 1'b0;
    post_bits = '0;
    ack_en = 1'b0;
    ack_delay = 4'h0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (reset_list[i]) rchk(reset_list[i], 8'h00);
    bus(1'b1, IDX_CPU_FLAGS, 8'h01);
    post(22'h00_0008);
    rchk(IDX_CLEAR_LOW, 8'h08);
    chk(32'(irq_req), 32'h0000_0000);
    rchk(IDX_VECTOR, 8'h00);
    bus(1'b1, IDX_MASK_LOW, 8'h08);
    rchk(IDX_MASK_LOW, 8'h08);
    chk(32'(irq_req), 32'h0000_0001);
    chk(32'(irq_vector), 32'h0000_0010);
    rchk(IDX_VECTOR, 8'h10);
    rchk(IDX_CLEAR_LOW, 8'h00);
    bus(1'b1, IDX_MASK_UPPER, 8'h20);
    bus(1'b1, IDX_MASK_MIDDLE, 8'h01);
    post(22'h20_0300);
    rchk(IDX_VECTOR, 8'h24);
    rchk(IDX_VECTOR, 8'h58);
    rchk(IDX_VECTOR, 8'h00);
    rchk(IDX_CLEAR_MIDDLE, 8'h02);
    bus(1'b1, IDX_CLEAR_MIDDLE, 8'h00);
    rchk(IDX_CLEAR_MIDDLE, 8'h00);
    bus(1'b1, IDX_CLEAR_UPPER, 8'h3f);
    rchk(IDX_CLEAR_UPPER, 8'h00);
    bus(1'b1, IDX_SOFT_EN, 8'h01);
    rchk(IDX_SOFT_EN, 8'h01);
    bus(1'b1, IDX_CLEAR_UPPER, 8'h20);
    bus(1'b1, IDX_CLEAR_UPPER, 8'h00);
    rchk(IDX_CLEAR_UPPER, 8'h20);
    rchk(IDX_VECTOR, 8'h58);
    bus(1'b1, IDX_CLEAR_LOW, 8'h81);
    bus(1'b1, IDX_CLEAR_MIDDLE, 8'h10);
    bus(1'b1, IDX_VECTOR, 8'h00);
    rchk(IDX_CLEAR_LOW, 8'h00);
    rchk(IDX_CLEAR_MIDDLE, 8'h00);
    bus(1'b1, IDX_SOFT_EN, 8'h00);
    // event output: enable, mask, clear
    bus(1'b1, IDX_EVT_ENABLE, 8'h04);
    @(posedge clock);
    chk(32'(irq_out), 32'h0000_0001);
    bus(1'b1, IDX_EVT_CLEAR, 8'h0f);
    @(posedge clock);
    chk(32'(irq_out), 32'h0000_0000);
    rchk(IDX_EVT_STATUS, 8'h00);
    rchk(IDX_EVT_CLEAR, 8'h00);
    bus(1'b1, IDX_EVT_ENABLE, 8'h01);
    post(22'h00_0001);
    chk(32'(irq_out), 32'h0000_0001);
    rchk(IDX_EVT_STATUS, 8'h01);
    bus(1'b1, IDX_EVT_ENABLE, 8'h00);
    @(posedge clock);
    chk(32'(irq_out), 32'h0000_0000);
    bus(1'b1, IDX_CLEAR_LOW, 8'h00);
    // core service, then a closed gate holding off the next request
    bus(1'b1, IDX_MASK_LOW, 8'hff);
    ack_en <= 1'b1;
    post(22'h00_0004);
    repeat (4) @(posedge clock);
    chk(32'(taken_vec), 32'h0000_000c);
    rchk(IDX_CPU_FLAGS, 8'h00);
    rchk(IDX_CLEAR_LOW, 8'h00);
    post(22'h00_0002);
    repeat (6) @(posedge clock);
    chk(32'(irq_req), 32'h0000_0000);
    rchk(IDX_CLEAR_LOW, 8'h02);
    ack_delay <= 4'h3;
    bus(1'b1, IDX_CPU_FLAGS, 8'h01);
    repeat (8) @(posedge clock);
    chk(32'(taken_vec), 32'h0000_0008);
    chk(32'(irq_req), 32'h0000_0000);
    rchk(IDX_EVT_STATUS, 8'h09);
    give_verdict();
  end
endmodule
